// >>> rtl/dtcm_timers.sv
// module: two 8032-style timer/counters with shared mode and control registers
`timescale 1ns/1ps
module dtcm_timers (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic INT_ACK_ZERO_IN,
  input wire logic INT_ACK_ONE_IN,
  input wire logic COUNT_PIN_ZERO_IN,
  input wire logic COUNT_PIN_ONE_IN,
  input wire logic GATE_PIN_ZERO_IN,
  input wire logic GATE_PIN_ONE_IN,
  output logic [7:0] SFR_RDATA_OUT,
  output logic OVERFLOW_FLAG_ZERO_OUT,
  output logic OVERFLOW_FLAG_ONE_OUT,
  output logic BAUD_PULSE_ONE_OUT
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [3:0] tick_div;
    // registered so every consumer sees the same one-cycle strobe
    logic tick;
    logic [7:0] mode_select;
    logic run_bit_zero;
    logic run_bit_one;
    logic overflow_flag_zero;
    logic overflow_flag_one;
    logic [7:0] count_low_zero;
    logic [7:0] count_high_zero;
    logic [7:0] count_low_one;
    logic [7:0] count_high_one;
    logic samp_zero;
    logic samp_one;
    logic pend_zero;
    logic pend_one;
    logic [7:0] rdata;
    logic baud_pulse;
  } dtcm_state_t;
  dtcm_state_t st_r;
  dtcm_state_t st_nxt;
  logic pin_c0;
  logic pin_c1;
  logic pin_g0;
  logic pin_g1;
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // the pins are asynchronous; only filtered levels reach the edge logic
  dtcm_pin_sync u_sync_c0 (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(COUNT_PIN_ZERO_IN),
    .level_out(pin_c0)
  );
  dtcm_pin_sync u_sync_c1 (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(COUNT_PIN_ONE_IN),
    .level_out(pin_c1)
  );
  dtcm_pin_sync u_sync_g0 (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(GATE_PIN_ZERO_IN),
    .level_out(pin_g0)
  );
  dtcm_pin_sync u_sync_g1 (
    .clk_in(CLOCK_IN),
    .rst_b_in(RST_B_IN),
    .pin_in(GATE_PIN_ONE_IN),
    .level_out(pin_g1)
  );
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic gate_ok(input logic run, input logic gate, input logic pin);
    gate_ok = run && (!gate || pin);
  endfunction : gate_ok
  // both timers decode their share of the mode register the same way
  function automatic logic [1:0] mode_field(input logic [7:0] sel, input int lsb);
    mode_field = sel[lsb +: 2];
  endfunction : mode_field
  // counter input: a 1 sample followed by a 0 sample arms one count
  function automatic logic arm_fall(input logic prev, input logic now);
    arm_fall = prev && !now;
  endfunction : arm_fall
  // control byte as the core reads it; external interrupt bits are not kept here
  function automatic logic [7:0] ctrl_byte(input logic f1, input logic r1, input logic f0,
                                           input logic r0);
    logic [7:0] b;
    b = 8'h00;
    b[dtcm_pkg::OVF_FLAG_ONE_BIT] = f1;
    b[dtcm_pkg::RUN_BIT_ONE_POS] = r1;
    b[dtcm_pkg::OVF_FLAG_ZERO_BIT] = f0;
    b[dtcm_pkg::RUN_BIT_ZERO_POS] = r0;
    return b;
  endfunction : ctrl_byte
  // full 16-bit / 13-bit step of one timer; returns {overflow, high, low}
  function automatic logic [16:0] step_wide(input logic [1:0] mode, input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [16:0] r;
    logic [5:0] pre;
    logic [8:0] h9;
    logic [16:0] w;
    r = {1'b0, hi, lo};
    pre = '0;
    h9 = '0;
    w = '0;
    if (mode == dtcm_pkg::DTCM_MODE_13BIT) begin
      // upper three low-byte bits are left alone: they carry no meaning here
      pre = {1'b0, lo[dtcm_pkg::PRESCALE_BITS-1:0]} + 6'h01;
      h9 = {1'b0, hi} + {8'h00, pre[dtcm_pkg::PRESCALE_BITS]};
      r = {h9[8], h9[7:0], lo[7:dtcm_pkg::PRESCALE_BITS],
           pre[dtcm_pkg::PRESCALE_BITS-1:0]};
    end else if (mode == dtcm_pkg::DTCM_MODE_16BIT) begin
      w = {1'b0, hi, lo} + 17'h00001;
      r = w;
    end else begin
      // reload mode: high byte keeps its preset value
      h9 = {1'b0, lo} + 9'h001;
      r = {h9[8], hi, (h9[8] ? hi : h9[7:0])};
    end
    return r;
  endfunction : step_wide
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic inc0;
    logic inc1;
    logic en0;
    logic en1;
    logic fall0;
    logic fall1;
    logic [16:0] res;
    logic [8:0] b9;
    logic ovf0;
    logic ovf1;
    logic baud;
    st_nxt = st_r;
    mode0 = mode_field(st_r.mode_select, dtcm_pkg::MODE_LSB_ZERO);
    mode1 = mode_field(st_r.mode_select, dtcm_pkg::MODE_LSB_ONE);
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    baud = 1'b0;
    res = '0;
    b9 = '0;
    // divider: one tick every twelve oscillator periods, free of bus activity
    st_nxt.tick = (st_r.tick_div == dtcm_pkg::TICK_DIV_LAST);
    st_nxt.tick_div = st_nxt.tick ? 4'h0 : st_r.tick_div + 4'h1;
    // counter inputs: a 1 sample then a 0 sample, counted on the following tick
    fall0 = 1'b0;
    fall1 = 1'b0;
    if (st_r.tick) begin
      fall0 = st_r.pend_zero;
      fall1 = st_r.pend_one;
      st_nxt.pend_zero = arm_fall(st_r.samp_zero, pin_c0);
      st_nxt.pend_one = arm_fall(st_r.samp_one, pin_c1);
      st_nxt.samp_zero = pin_c0;
      st_nxt.samp_one = pin_c1;
    end
    inc0 = st_r.mode_select[dtcm_pkg::FUNC_BIT_ZERO] ? fall0 : st_r.tick;
    inc1 = st_r.mode_select[dtcm_pkg::FUNC_BIT_ONE] ? fall1 : st_r.tick;
    en0 = gate_ok(st_r.run_bit_zero, st_r.mode_select[dtcm_pkg::GATE_BIT_ZERO],
                  pin_g0);
    en1 = gate_ok(st_r.run_bit_one, st_r.mode_select[dtcm_pkg::GATE_BIT_ONE],
                  pin_g1);
    // timer 0
    if (en0 && inc0) begin
      if (mode0 == dtcm_pkg::DTCM_MODE_SPLIT) begin
        b9 = {1'b0, st_r.count_low_zero} + 9'h001;
        st_nxt.count_low_zero = b9[7:0];
        ovf0 = b9[8];
      end else begin
        res = step_wide(mode0, st_r.count_high_zero, st_r.count_low_zero);
        st_nxt.count_high_zero = res[15:8];
        st_nxt.count_low_zero = res[7:0];
        ovf0 = res[16];
      end
    end
    // split high byte: always tick-driven, steered by timer 1's run bit only
    if (mode0 == dtcm_pkg::DTCM_MODE_SPLIT && st_r.run_bit_one && st_r.tick) begin
      b9 = {1'b0, st_r.count_high_zero} + 9'h001;
      st_nxt.count_high_zero = b9[7:0];
      ovf1 = b9[8];
    end
    // timer 1: mode 11b halts it; while timer 0 is split its run bit is borrowed,
    // so it free-runs for the baud logic and its flag belongs to timer 0's high byte
    if (mode1 != dtcm_pkg::DTCM_MODE_SPLIT && inc1 &&
        (mode0 == dtcm_pkg::DTCM_MODE_SPLIT ||
         en1)) begin
      res = step_wide(mode1, st_r.count_high_one, st_r.count_low_one);
      st_nxt.count_high_one = res[15:8];
      st_nxt.count_low_one = res[7:0];
      baud = res[16];
      if (mode0 != dtcm_pkg::DTCM_MODE_SPLIT) begin
        ovf1 = res[16];
      end
    end
    st_nxt.baud_pulse = baud;
    // flags: set wins over the service clear
    if (INT_ACK_ZERO_IN) begin
      st_nxt.overflow_flag_zero = 1'b0;
    end
    if (INT_ACK_ONE_IN) begin
      st_nxt.overflow_flag_one = 1'b0;
    end
    // ****************************************************************
    // register writes; software writes to count bytes win over counting
    // ****************************************************************
    // a count byte written during a tick takes the written value and that tick is lost
    if (SFR_WR_IN) begin
      unique case (SFR_ADDR_IN)
        dtcm_pkg::ADDR_MODE_SELECT: begin
          st_nxt.mode_select = SFR_WDATA_IN;
        end
        dtcm_pkg::ADDR_RUN_FLAG_CTRL: begin
          // run bits only; counts are untouched when a timer starts
          st_nxt.run_bit_zero = SFR_WDATA_IN[dtcm_pkg::RUN_BIT_ZERO_POS];
          st_nxt.run_bit_one = SFR_WDATA_IN[dtcm_pkg::RUN_BIT_ONE_POS];
        end
        dtcm_pkg::ADDR_COUNT_LOW_ZERO: begin
          st_nxt.count_low_zero = SFR_WDATA_IN;
        end
        dtcm_pkg::ADDR_COUNT_HIGH_ZERO: begin
          st_nxt.count_high_zero = SFR_WDATA_IN;
        end
        dtcm_pkg::ADDR_COUNT_LOW_ONE: begin
          st_nxt.count_low_one = SFR_WDATA_IN;
        end
        dtcm_pkg::ADDR_COUNT_HIGH_ONE: begin
          st_nxt.count_high_one = SFR_WDATA_IN;
        end
        default: begin
        end
      endcase
    end
    // set after the clear so an overflow in the cycle of an ack is never lost
    if (ovf0) begin
      st_nxt.overflow_flag_zero = 1'b1;
    end
    if (ovf1) begin
      st_nxt.overflow_flag_one = 1'b1;
    end
    // ****************************************************************
    // read data, registered; unmapped addresses read zero
    // ****************************************************************
    // counts are read a byte at a time; a carry between the two reads is not caught
    unique case (SFR_ADDR_IN)
      dtcm_pkg::ADDR_MODE_SELECT: st_nxt.rdata = st_r.mode_select;
      dtcm_pkg::ADDR_RUN_FLAG_CTRL: st_nxt.rdata = ctrl_byte(st_r.overflow_flag_one,
        st_r.run_bit_one, st_r.overflow_flag_zero, st_r.run_bit_zero);
      dtcm_pkg::ADDR_COUNT_LOW_ZERO: st_nxt.rdata = st_r.count_low_zero;
      dtcm_pkg::ADDR_COUNT_HIGH_ZERO: st_nxt.rdata = st_r.count_high_zero;
      dtcm_pkg::ADDR_COUNT_LOW_ONE: st_nxt.rdata = st_r.count_low_one;
      dtcm_pkg::ADDR_COUNT_HIGH_ONE: st_nxt.rdata = st_r.count_high_one;
      default: st_nxt.rdata = 8'h00;
    endcase
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      st_r <= '0;
      // mode and count reset values applied on top of the clear; RUN_FLAG_CTRL_RESET is not applied, run bits and flags stay cleared
      st_r.mode_select <= dtcm_pkg::MODE_SELECT_RESET;
      st_r.count_low_zero <= dtcm_pkg::COUNT_RESET;
      st_r.count_high_zero <= dtcm_pkg::COUNT_RESET;
      st_r.count_low_one <= dtcm_pkg::COUNT_RESET;
      st_r.count_high_one <= dtcm_pkg::COUNT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign SFR_RDATA_OUT = st_r.rdata;
  assign OVERFLOW_FLAG_ZERO_OUT = st_r.overflow_flag_zero;
  assign OVERFLOW_FLAG_ONE_OUT = st_r.overflow_flag_one;
  assign BAUD_PULSE_ONE_OUT = st_r.baud_pulse;
endmodule : dtcm_timers

// >>> pkg/dtcm_pkg.sv
// package: register map, field positions and timing constants of the dual timer/counter
package dtcm_pkg;
  // ****************************************************************
  // register addresses on the special function register bus
  // ****************************************************************
  localparam logic [7:0] ADDR_RUN_FLAG_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
  localparam logic [7:0] ADDR_COUNT_LOW_ZERO = 8'h8A;
  localparam logic [7:0] ADDR_COUNT_LOW_ONE = 8'h8B;
  localparam logic [7:0] ADDR_COUNT_HIGH_ZERO = 8'h8C;
  localparam logic [7:0] ADDR_COUNT_HIGH_ONE = 8'h8D;
  localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
  localparam logic [7:0] RUN_FLAG_CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int GATE_BIT_ONE = 7;
  localparam int FUNC_BIT_ONE = 6;
  localparam int MODE_LSB_ONE = 4;
  localparam int GATE_BIT_ZERO = 3;
  localparam int FUNC_BIT_ZERO = 2;
  localparam int MODE_LSB_ZERO = 0;
  localparam int OVF_FLAG_ONE_BIT = 7;
  localparam int RUN_BIT_ONE_POS = 6;
  localparam int OVF_FLAG_ZERO_BIT = 5;
  localparam int RUN_BIT_ZERO_POS = 4;
  localparam int PRESCALE_BITS = 5;
  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [1:0] {
    DTCM_MODE_13BIT = 2'b00,
    DTCM_MODE_16BIT = 2'b01,
    DTCM_MODE_RELOAD = 2'b10,
    DTCM_MODE_SPLIT = 2'b11
  } dtcm_mode_t;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int OSC_PER_TICK = 12;
  localparam logic [3:0] TICK_DIV_LAST = 4'(OSC_PER_TICK - 1);
endpackage : dtcm_pkg

// >>> rtl/dtcm_pin_sync.sv
// module: three-stage pin synchroniser with agreement check
`timescale 1ns/1ps
module dtcm_pin_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dtcm_sync_t;
  dtcm_sync_t st_r;
  dtcm_sync_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a change only counts once the two late stages agree
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level_out = st_r.lvl;
endmodule : dtcm_pin_sync

// >>> test/dtcm_chk.sv
// checker: port-level properties of the dual timer/counter
`timescale 1ns/1ps
module dtcm_chk (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic INT_ACK_ZERO_IN,
  input wire logic INT_ACK_ONE_IN,
  input wire logic COUNT_PIN_ZERO_IN,
  input wire logic COUNT_PIN_ONE_IN,
  input wire logic GATE_PIN_ZERO_IN,
  input wire logic GATE_PIN_ONE_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  input wire logic OVERFLOW_FLAG_ZERO_OUT,
  input wire logic OVERFLOW_FLAG_ONE_OUT,
  input wire logic BAUD_PULSE_ONE_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  a_flag_zero_hold: assert property (
    OVERFLOW_FLAG_ZERO_OUT && !INT_ACK_ZERO_IN |=> OVERFLOW_FLAG_ZERO_OUT)
    else $error("flag zero dropped without service");
  a_flag_one_hold: assert property (
    OVERFLOW_FLAG_ONE_OUT && !INT_ACK_ONE_IN |=> OVERFLOW_FLAG_ONE_OUT)
    else $error("flag one dropped without service");
  // overflows are tick-paced, so a pulse within eight cycles of the last one means a broken divider
  a_baud_spacing: assert property (
    BAUD_PULSE_ONE_OUT |=> !BAUD_PULSE_ONE_OUT [*8])
    else $error("baud pulse too long or too dense");
  a_mode_readback: assert property (
    SFR_WR_IN && SFR_ADDR_IN == 8'h89 ##1 !SFR_WR_IN && SFR_ADDR_IN == 8'h89
      |=> SFR_RDATA_OUT == $past(SFR_WDATA_IN, 2))
    else $error("mode register read back differs");
  a_run_readback: assert property (
    SFR_WR_IN && SFR_ADDR_IN == 8'h88 ##1 !SFR_WR_IN && SFR_ADDR_IN == 8'h88
      |=> (SFR_RDATA_OUT & 8'h50) == ($past(SFR_WDATA_IN, 2) & 8'h50))
    else $error("run bits read back differ");
  a_ctrl_flags_read: assert property (
    SFR_ADDR_IN == 8'h88 |=> SFR_RDATA_OUT[7] == $past(OVERFLOW_FLAG_ONE_OUT)
      && SFR_RDATA_OUT[5] == $past(OVERFLOW_FLAG_ZERO_OUT) && SFR_RDATA_OUT[3:0] == 4'h0)
    else $error("control read does not show flags");
  a_unmapped_zero: assert property (
    SFR_ADDR_IN < 8'h88 || SFR_ADDR_IN > 8'h8D |=> SFR_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clears: assert property (disable iff (1'b0)
    !RST_B_IN |=> SFR_RDATA_OUT == 8'h00 && !OVERFLOW_FLAG_ZERO_OUT && !OVERFLOW_FLAG_ONE_OUT)
    else $error("reset left outputs set");
  c_baud: cover property (BAUD_PULSE_ONE_OUT);
  c_flag_zero: cover property ($rose(OVERFLOW_FLAG_ZERO_OUT));
  c_flag_one: cover property ($rose(OVERFLOW_FLAG_ONE_OUT));
endmodule : dtcm_chk
bind dtcm_timers dtcm_chk chk_i (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
  .SFR_WR_IN(SFR_WR_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
  .INT_ACK_ZERO_IN(INT_ACK_ZERO_IN), .INT_ACK_ONE_IN(INT_ACK_ONE_IN),
  .COUNT_PIN_ZERO_IN(COUNT_PIN_ZERO_IN), .COUNT_PIN_ONE_IN(COUNT_PIN_ONE_IN),
  .GATE_PIN_ZERO_IN(GATE_PIN_ZERO_IN), .GATE_PIN_ONE_IN(GATE_PIN_ONE_IN),
  .SFR_RDATA_OUT(SFR_RDATA_OUT), .OVERFLOW_FLAG_ZERO_OUT(OVERFLOW_FLAG_ZERO_OUT),
  .OVERFLOW_FLAG_ONE_OUT(OVERFLOW_FLAG_ONE_OUT), .BAUD_PULSE_ONE_OUT(BAUD_PULSE_ONE_OUT));

// >>> test/dtcm_cpu_model.sv
// cpu side model: register writes, reads and interrupt service
`timescale 1ns/1ps
module dtcm_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic ack0_out,
  output logic ack1_out
);
  initial begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
    ack0_out = 1'b0;
    ack1_out = 1'b0;
  end
  // callers set mode and presets before any run bit, except s_split, which rewrites them while timer one's run bit is set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
    @(posedge clk_in);
  endtask : wr
  // read data is registered one edge after the address; look mid-cycle, not on the edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_out <= a;
    @(posedge clk_in);
    @(negedge clk_in);
    d = rdata_in;
    @(posedge clk_in);
  endtask : rd
  // extra edge so the cleared flag is settled when the caller looks
  task automatic ack(input logic [1:0] m);
    ack0_out <= m[0];
    ack1_out <= m[1];
    @(posedge clk_in);
    ack0_out <= 1'b0;
    ack1_out <= 1'b0;
    @(posedge clk_in);
  endtask : ack
endmodule : dtcm_cpu_model

// >>> test/tb_top.sv
// bench: directed scenarios for the dual timer/counter
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cp0, cp1, gp0, gp1;
  logic wr, ack0, ack1, f0, f1, baud;
  logic [7:0] addr, wdata, rdata;
  int errors = 0;
  int total_checks = 0;
  int n;
  always #20 clk = ~clk;
  dtcm_timers dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .SFR_WR_IN(wr), .SFR_ADDR_IN(addr),
    .SFR_WDATA_IN(wdata), .INT_ACK_ZERO_IN(ack0), .INT_ACK_ONE_IN(ack1),
    .COUNT_PIN_ZERO_IN(cp0), .COUNT_PIN_ONE_IN(cp1), .GATE_PIN_ZERO_IN(gp0),
    .GATE_PIN_ONE_IN(gp1), .SFR_RDATA_OUT(rdata), .OVERFLOW_FLAG_ZERO_OUT(f0),
    .OVERFLOW_FLAG_ONE_OUT(f1), .BAUD_PULSE_ONE_OUT(baud));
  dtcm_cpu_model cpu (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .addr_out(addr),
    .wdata_out(wdata), .ack0_out(ack0), .ack1_out(ack1));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk($sformatf("sfr %h", a), d, e);
  endtask : rchk
  // bounded wait on flag zero, flag one or the baud pulse, looked at mid-cycle; n counts cycles
  task automatic wsig(input int s);
    n = 0;
    @(negedge clk);
    while ((s == 0 ? f0 : s == 1 ? f1 : baud) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 900) begin
        errors++;
        tally_and_finish();
      end
    end
    @(posedge clk);
  endtask : wsig
  // ****
  // scenarios
  // ****
  task automatic s_regs();
    for (int i = 0; i < 6; i++) rchk(8'h88 + 8'(i), 8'h00);
    cpu.wr(8'h90, 8'h5A);
    rchk(8'h90, 8'h00);
    cpu.wr(8'h89, 8'hA5);
    rchk(8'h89, 8'hA5);
  endtask : s_regs
  task automatic s_reload();
    cpu.wr(8'h89, 8'h02);
    cpu.wr(8'h8C, 8'hFE);
    cpu.wr(8'h8A, 8'hFE);
    cpu.wr(8'h88, 8'h10);
    wsig(0);
    cpu.ack(2'b01);
    wsig(0);
    // two ticks per reload period, less the closing edge of the first wait and the two edges spent on the ack
    chk("reload period", 8'(n), 8'(2 * dtcm_pkg::OSC_PER_TICK - 3));
    rchk(8'h8A, 8'hFE);
    rchk(8'h8C, 8'hFE);
    cpu.wr(8'h88, 8'h00);
    cpu.ack(2'b01);
    chk("flag zero", {7'h00, f0}, 8'h00);
  endtask : s_reload
  task automatic s_modes();
    for (int m = 0; m < 2; m++) begin
      cpu.wr(8'h89, 8'(m));
      cpu.wr(8'h8C, 8'hFF);
      cpu.wr(8'h8A, 8'hFF);
      cpu.wr(8'h88, 8'h10);
      wsig(0);
      cpu.wr(8'h88, 8'h00);
      rchk(8'h8A, m ? 8'h00 : 8'hE0);
      rchk(8'h8C, 8'h00);
      cpu.ack(2'b01);
    end
  endtask : s_modes
  task automatic s_gate();
    cpu.wr(8'h89, 8'h09);
    cpu.wr(8'h8A, 8'hFF);
    cpu.wr(8'h8C, 8'hFF);
    cpu.wr(8'h88, 8'h10);
    repeat (40) @(posedge clk);
    rchk(8'h8A, 8'hFF);
    gp0 <= 1'b1;
    wsig(0);
    gp0 <= 1'b0;
    cpu.wr(8'h88, 8'h00);
    cpu.ack(2'b01);
  endtask : s_gate
  task automatic s_count();
    cpu.wr(8'h89, 8'h60);
    cpu.wr(8'h8B, 8'hFF);
    cpu.wr(8'h8D, 8'hFF);
    cpu.wr(8'h88, 8'h40);
    repeat (60) @(posedge clk);
    rchk(8'h8B, 8'hFF);
    cp1 <= 1'b0;
    wsig(2);
    chk("flag one", {7'h00, f1}, 8'h01);
    rchk(8'h8B, 8'hFF);
    cp1 <= 1'b1;
    cpu.wr(8'h88, 8'h00);
    cpu.ack(2'b10);
  endtask : s_count
  // timer zero split; timer one parks in its own mode 3 and restarts
  task automatic s_split();
    cpu.wr(8'h89, 8'h23);
    cpu.wr(8'h8A, 8'hFF);
    cpu.wr(8'h8C, 8'hFF);
    cpu.wr(8'h88, 8'h40);
    wsig(1);
    rchk(8'h8A, 8'hFF);
    wsig(2);
    cpu.wr(8'h89, 8'h33);
    cpu.wr(8'h8B, 8'hFE);
    repeat (40) @(posedge clk);
    rchk(8'h8B, 8'hFE);
    cpu.wr(8'h89, 8'h23);
    wsig(2);
    cpu.wr(8'h88, 8'h10);
    wsig(0);
    cpu.wr(8'h88, 8'h00);
    cpu.ack(2'b11);
  endtask : s_split
  // counter function on timer zero's pin, gate pin on timer one
  task automatic s_pins();
    cpu.wr(8'h89, 8'hA6);
    cpu.wr(8'h8A, 8'hFF);
    cpu.wr(8'h8C, 8'h80);
    cpu.wr(8'h8B, 8'hFF);
    cpu.wr(8'h88, 8'h50);
    repeat (40) @(posedge clk);
    rchk(8'h8A, 8'hFF);
    rchk(8'h8B, 8'hFF);
    chk("flag one gated", {7'h00, f1}, 8'h00);
    cp0 <= 1'b0;
    gp1 <= 1'b1;
    wsig(1);
    wsig(0);
    rchk(8'h8A, 8'h80);
    cp0 <= 1'b1;
    gp1 <= 1'b0;
    cpu.wr(8'h88, 8'h00);
    cpu.ack(2'b11);
  endtask : s_pins
  initial begin
    cp0 <= 1'b1;
    cp1 <= 1'b1;
    gp0 <= 1'b0;
    gp1 <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    s_regs();
    s_reload();
    s_modes();
    s_gate();
    s_count();
    s_split();
    s_pins();
    tally_and_finish();
  end
endmodule : tb_top
